/* File: verilog/acdr_rx.sv */
// Asynchronous receiver clock and data recovery with a Wishbone register file.
// Assumes RXD is asynchronous to MCLK and a classic single-cycle bus master.
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module acdr_rx (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Serial line and interrupt
	input wire logic RXD,
	output logic IRQ
);
	acdr_pkg::acdr_cfg_s cfg_q;
	acdr_pkg::acdr_frame_s frame_q;
	acdr_pkg::acdr_state_e state_q;
	logic [11:0] baud_divisor_value_q;
	logic [11:0] baud_cnt_q;
	logic tick_q;
	logic rxd_meta_q;
	logic rxd_sync_q;
	logic prev_q;
	logic [4:0] samp_q;
	logic [4:0] samp_d;
	logic [1:0] vote_q;
	logic [3:0] bit_cnt_q;
	logic [8:0] shreg_q;
	logic par_acc_q;
	logic par_bit_q;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic [4:0] spb;
	logic [4:0] first_vote;
	logic [3:0] nbits;
	logic vote_now;
	logic bit_val;
	logic start_det;
	logic set_frame;
	logic set_stop_err;
	logic set_par_err;
	logic set_noise;
	logic par_err;
	logic bus_req;
	logic bus_wr;
	logic [3:0] status_clr;

	// Two-flop synchroniser on the serial line
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rxd_meta_q <= 1'b1;
			rxd_sync_q <= 1'b1;
		end else begin
			rxd_meta_q <= RXD;
			rxd_sync_q <= rxd_meta_q;
		end
	end

	// Sample enable from the baud divisor
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			baud_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (baud_cnt_q == '0);
			if (baud_cnt_q == '0) begin
				baud_cnt_q <= baud_divisor_value_q;
			end else begin
				baud_cnt_q <= baud_cnt_q - 12'h001;
			end
		end
	end

	// Mode dependent sampling figures
	always_comb begin
		if (cfg_q.double_speed_select) begin
			spb = acdr_pkg::SPB_DOUBLE;
			first_vote = acdr_pkg::FIRST_VOTE_DOUBLE;
		end else begin
			spb = acdr_pkg::SPB_NORMAL;
			first_vote = acdr_pkg::FIRST_VOTE_NORMAL;
		end
		if (cfg_q.char_size > acdr_pkg::SIZE_MAX_CODE) begin
			nbits = acdr_pkg::SIZE_BASE + {1'b0, acdr_pkg::SIZE_MAX_CODE};
		end else begin
			nbits = acdr_pkg::SIZE_BASE + {1'b0, cfg_q.char_size};
		end
	end

	// Sample numbering, voting moment and majority
	always_comb begin
		samp_d = (samp_q == spb) ? 5'h01 : samp_q + 5'h01;
		vote_now = tick_q && (state_q != acdr_pkg::RX_IDLE) && (samp_d == first_vote + acdr_pkg::VOTE_SPAN);
		bit_val = (vote_q[1] & vote_q[0]) | (vote_q[1] & rxd_sync_q) | (vote_q[0] & rxd_sync_q);
		start_det = tick_q && cfg_q.rx_en && (state_q == acdr_pkg::RX_IDLE) && prev_q && !rxd_sync_q;
		par_err = cfg_q.parity_enable && ((par_acc_q ^ par_bit_q) != cfg_q.parity_odd_select);
		set_noise = vote_now && (state_q == acdr_pkg::RX_START) && bit_val;
		set_frame = vote_now && (state_q == acdr_pkg::RX_STOP);
		set_stop_err = set_frame && !bit_val;
		set_par_err = set_frame && par_err;
	end

	// Receive state machine
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			state_q <= acdr_pkg::RX_IDLE;
		end else if (!cfg_q.rx_en) begin
			state_q <= acdr_pkg::RX_IDLE;
		end else if (start_det) begin
			state_q <= acdr_pkg::RX_START;
		end else if (vote_now) begin
			case (state_q)
				acdr_pkg::RX_START: begin
					state_q <= bit_val ? acdr_pkg::RX_IDLE : acdr_pkg::RX_DATA;
				end
				acdr_pkg::RX_DATA: begin
					if (bit_cnt_q == nbits - 4'h1) begin
						state_q <= cfg_q.parity_enable ? acdr_pkg::RX_PARITY : acdr_pkg::RX_STOP;
					end
				end
				acdr_pkg::RX_PARITY: begin
					state_q <= acdr_pkg::RX_STOP;
				end
				acdr_pkg::RX_STOP: begin
					state_q <= acdr_pkg::RX_IDLE;
				end
				default: begin
					state_q <= acdr_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Sample counter, vote history and previous sample
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			samp_q <= '0;
			vote_q <= '0;
			prev_q <= 1'b1;
		end else if (tick_q) begin
			prev_q <= rxd_sync_q;
			if (start_det) begin
				samp_q <= 5'h01;
			end else if (state_q != acdr_pkg::RX_IDLE) begin
				samp_q <= samp_d;
				if (samp_d >= first_vote && samp_d < first_vote + acdr_pkg::VOTE_SPAN) begin
					vote_q <= {vote_q[0], rxd_sync_q};
				end
			end
		end
	end

	// Data shift register and parity accumulation
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			bit_cnt_q <= '0;
			shreg_q <= '0;
			par_acc_q <= 1'b0;
			par_bit_q <= 1'b0;
		end else if (start_det) begin
			bit_cnt_q <= '0;
			shreg_q <= '0;
			par_acc_q <= 1'b0;
			par_bit_q <= 1'b0;
		end else if (vote_now && state_q == acdr_pkg::RX_DATA) begin
			shreg_q[bit_cnt_q] <= bit_val;
			par_acc_q <= par_acc_q ^ bit_val;
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end else if (vote_now && state_q == acdr_pkg::RX_PARITY) begin
			par_bit_q <= bit_val;
		end
	end

	// Received frame holding register
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			frame_q <= '0;
		end else if (set_frame) begin
			frame_q.data <= shreg_q;
			frame_q.stop_bit_error_flag <= !bit_val;
			frame_q.par_err <= par_err;
		end
	end

	// Bus handshake
	always_comb begin
		bus_req = WB_CYC_I && WB_STB_I;
		bus_wr = bus_req && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
		status_clr = '0;
		if (bus_wr && WB_ADR_I == acdr_pkg::ADDR_STATUS) begin
			status_clr = WB_DAT_I[3:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req && !WB_ACK_O;
		end
	end

	// Configuration registers
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			cfg_q <= acdr_pkg::CTRL_RESET;
			baud_divisor_value_q <= acdr_pkg::BAUD_RESET;
			mask_q <= '0;
		end else if (bus_wr) begin
			case (WB_ADR_I)
				acdr_pkg::ADDR_CTRL: begin
					cfg_q <= WB_DAT_I[6:0];
				end
				acdr_pkg::ADDR_BAUD: begin
					if (WB_SEL_I[1]) begin
						baud_divisor_value_q <= WB_DAT_I[11:0];
					end else begin
						baud_divisor_value_q[7:0] <= WB_DAT_I[7:0];
					end
				end
				acdr_pkg::ADDR_MASK: begin
					mask_q <= WB_DAT_I[3:0];
				end
				default: begin
					mask_q <= mask_q;
				end
			endcase
		end
	end

	// Sticky status, set wins over a write-one clear
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			status_q <= '0;
		end else begin
			status_q[acdr_pkg::ST_FRAME] <= set_frame
				|| (status_q[acdr_pkg::ST_FRAME] && !status_clr[acdr_pkg::ST_FRAME]);
			status_q[acdr_pkg::ST_STOP_ERR] <= set_stop_err
				|| (status_q[acdr_pkg::ST_STOP_ERR] && !status_clr[acdr_pkg::ST_STOP_ERR]);
			status_q[acdr_pkg::ST_PAR_ERR] <= set_par_err
				|| (status_q[acdr_pkg::ST_PAR_ERR] && !status_clr[acdr_pkg::ST_PAR_ERR]);
			status_q[acdr_pkg::ST_NOISE] <= set_noise
				|| (status_q[acdr_pkg::ST_NOISE] && !status_clr[acdr_pkg::ST_NOISE]);
		end
	end

	// Interrupt output
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status_q & mask_q);
		end
	end

	// Read data, captured on the request cycle and shown with ack
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			WB_DAT_O <= '0;
		end else if (bus_req && !WB_ACK_O) begin
			case (WB_ADR_I)
				acdr_pkg::ADDR_CTRL: begin
					WB_DAT_O <= {25'h0, cfg_q};
				end
				acdr_pkg::ADDR_BAUD: begin
					WB_DAT_O <= {20'h00000, baud_divisor_value_q};
				end
				acdr_pkg::ADDR_STATUS: begin
					WB_DAT_O <= {28'h0000000, status_q};
				end
				acdr_pkg::ADDR_MASK: begin
					WB_DAT_O <= {28'h0000000, mask_q};
				end
				acdr_pkg::ADDR_DATA: begin
					WB_DAT_O <= {21'h0, frame_q};
				end
				acdr_pkg::ADDR_STATE: begin
					WB_DAT_O <= {20'h00000, bit_cnt_q, samp_q, state_q};
				end
				default: begin
					WB_DAT_O <= '0;
				end
			endcase
		end
	end

	// Checks
	a_sync_two_flops: assert property (@(posedge MCLK) disable iff (RESET)
		##2 (rxd_sync_q == $past(RXD, 2)))
		else $error("line synchroniser is not two flops deep");

	a_speed_select: assert property (@(posedge MCLK) disable iff (RESET)
		(tick_q && state_q != acdr_pkg::RX_IDLE && !start_det
		&& samp_q == (cfg_q.double_speed_select ? 5'h08 : 5'h10)) |=> (samp_q == 5'h01))
		else $error("bit period does not follow speed select");

	a_sample_range: assert property (@(posedge MCLK) disable iff (RESET)
		(state_q != acdr_pkg::RX_IDLE) |-> (samp_q >= 5'h01 && samp_q <= spb))
		else $error("sample number outside one bit");

	a_start_entry: assert property (@(posedge MCLK) disable iff (RESET)
		(tick_q && cfg_q.rx_en && state_q == acdr_pkg::RX_IDLE && prev_q && !rxd_sync_q)
		|=> (state_q == acdr_pkg::RX_START && samp_q == 5'h01))
		else $error("falling edge did not start detection");

	a_start_vote_point: assert property (@(posedge MCLK) disable iff (RESET)
		(vote_now && state_q == acdr_pkg::RX_START)
		|-> (samp_d == (cfg_q.double_speed_select ? 5'h06 : 5'h0a)))
		else $error("start vote at wrong sample");

	a_noise_reject: assert property (@(posedge MCLK) disable iff (RESET)
		(cfg_q.rx_en && vote_now && state_q == acdr_pkg::RX_START && bit_val)
		|=> (state_q == acdr_pkg::RX_IDLE && status_q[acdr_pkg::ST_NOISE]))
		else $error("noisy start not rejected");

	a_stop_error: assert property (@(posedge MCLK) disable iff (RESET)
		(set_frame && !bit_val) |=> (frame_q.stop_bit_error_flag && status_q[acdr_pkg::ST_STOP_ERR]))
		else $error("low stop bit did not flag an error");

	a_early_restart: assert property (@(posedge MCLK) disable iff (RESET)
		(cfg_q.rx_en && set_frame) |=> (state_q == acdr_pkg::RX_IDLE))
		else $error("receiver waits past stop vote");

	a_parity_off: assert property (@(posedge MCLK) disable iff (RESET)
		(set_frame && !cfg_q.parity_enable) |=> !frame_q.par_err)
		else $error("parity error flagged while parity disabled");

	a_irq_follows: assert property (@(posedge MCLK) disable iff (RESET)
		(|(status_q & mask_q)) |=> IRQ)
		else $error("interrupt missing for masked status");

	a_irq_quiet: assert property (@(posedge MCLK) disable iff (RESET)
		!(|(status_q & mask_q)) |=> !IRQ)
		else $error("interrupt raised without masked status");

	a_ack_single: assert property (@(posedge MCLK) disable iff (RESET)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

/* File: verilog/acdr_pkg.sv */
// Constants, register map and carrier types of the asynchronous receiver.
// Assumes one system clock and a Wishbone classic register bus.
//
// Overview of operation
// - Oversample sixteen times, or eight in double speed
// - Double speed when double_speed_select is one
// - High-to-low line transition starts start detection
// - Start judged on samples 8-10 or 4-6
// - Majority high start is noise; search again
// - Realign bit timing on every valid start
// - Sixteen or eight sampling states per bit
// - Bit value is majority of three centre samples
// - Recover data, parity and first stop only
// - Low stop bit sets stop_bit_error_flag
// - Accept next start right after stop vote
// - Data plus parity spans five to ten bits
// - Parity checked only when parity_enable set
// - Double speed cuts divisor from sixteen to eight
package acdr_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BAUD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam logic [7:0] ADDR_DATA = 8'h10;
	localparam logic [7:0] ADDR_STATE = 8'h14;
	// Control register fields
	localparam int CTRL_RX_EN = 0;
	localparam int CTRL_DBL = 1;
	localparam int CTRL_PAR_EN = 2;
	localparam int CTRL_PAR_ODD = 3;
	localparam int CTRL_SIZE_LO = 4;
	localparam logic [6:0] CTRL_RESET = 7'h31;
	// Status and mask bit positions
	localparam int ST_FRAME = 0;
	localparam int ST_STOP_ERR = 1;
	localparam int ST_PAR_ERR = 2;
	localparam int ST_NOISE = 3;
	localparam int ST_WIDTH = 4;
	// Data register fields
	localparam int DATA_STOP_ERR = 9;
	localparam int DATA_PAR_ERR = 10;
	// Baud divisor
	localparam int BAUD_W = 12;
	localparam logic [11:0] BAUD_RESET = 12'h019;
	// Sampling per bit and first voting sample
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] FIRST_VOTE_NORMAL = 5'h08;
	localparam logic [4:0] FIRST_VOTE_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_SPAN = 5'h02;
	// Character size
	localparam logic [2:0] SIZE_MAX_CODE = 3'h4;
	localparam logic [3:0] SIZE_BASE = 4'h5;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} acdr_state_e;

	typedef struct packed {
		logic [2:0] char_size;
		logic parity_odd_select;
		logic parity_enable;
		logic double_speed_select;
		logic rx_en;
	} acdr_cfg_s;

	typedef struct packed {
		logic par_err;
		logic stop_bit_error_flag;
		logic [8:0] data;
	} acdr_frame_s;
endpackage

/* File: verif/acdr_tx_model.sv */
// Remote asynchronous transmitter driving the serial line of the receiver.
// Assumes send is called just after a rising clock edge; the line idles high.
`timescale 1ns/100ps
`default_nettype none
module acdr_tx_model (
	// Clock
	input wire logic clk,
	// Serial line
	output logic rxd
);
	initial rxd = 1'b1;

	// Holds one level for a number of clocks at an exact bit rate
	task automatic hold(input logic v, input int c);
		rxd <= v;
		repeat (c) @(posedge clk);
	endtask

	// One frame: start, data LSB first, optional parity, stop of any length
	task automatic send(input logic [8:0] d, input int n, input int par, input logic stp,
		input int bitc, input int stopc);
		hold(1'b0, bitc);
		for (int i = 0; i < n; i++) begin
			hold(d[i], bitc);
		end
		if (par >= 0) begin
			hold(par[0], bitc);
		end
		hold(stp, stopc);
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: verif/acdr_rx_test.sv */
// Self-checking bench of the asynchronous receiver.
// Assumes the bus answers by ack and the partner model drives the line.
`timescale 1ns/100ps
`default_nettype none
module acdr_rx_test;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic rxd;
	logic irq;
	int mismatches = 0;
	int compares = 0;
	logic [31:0] q;

	always #12.5 mclk = ~mclk;

	acdr_rx i_dut (.MCLK(mclk), .RESET(reset), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
		.WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(4'hf), .WB_DAT_I(wb_dat_w),
		.WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack), .RXD(rxd), .IRQ(irq));
	acdr_tx_model i_tx (.clk(mclk), .rxd(rxd));

	task automatic end_sim();
		$display("Counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge mclk);
		if (n == 50) begin
			mismatches++;
			end_sim();
		end
	endtask

	// Configures, sends one frame, waits for it and checks status and data
	task automatic frame(input logic [6:0] cfg, input logic [8:0] d, input int n, input int par,
		input logic stp, input int bitc, input int stopc, input logic [31:0] st,
		input logic [31:0] dat);
		int k;
		k = 0;
		wb(1'b1, acdr_pkg::ADDR_CTRL, {25'h0, cfg});
		i_tx.send(d, n, par, stp, bitc, stopc);
		do begin
			wb(1'b0, acdr_pkg::ADDR_STATUS, 32'h0);
			k++;
		end while (q[0] !== 1'b1 && k < 200);
		if (k == 200) begin
			mismatches++;
			end_sim();
		end
		chk(q, st, "status");
		wb(1'b0, acdr_pkg::ADDR_DATA, 32'h0);
		chk(q, dat, "data");
		wb(1'b1, acdr_pkg::ADDR_STATUS, 32'hf);
	endtask

	task automatic t_regs();
		wb(1'b0, acdr_pkg::ADDR_CTRL, 32'h0);
		chk(q, {25'h0, acdr_pkg::CTRL_RESET}, "ctrl reset");
		wb(1'b0, acdr_pkg::ADDR_BAUD, 32'h0);
		chk(q, {20'h0, acdr_pkg::BAUD_RESET}, "baud reset");
		wb(1'b0, acdr_pkg::ADDR_STATE, 32'h0);
		chk(q, 32'h0, "state idle");
		wb(1'b1, 8'h18, 32'hff);
		wb(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0, "unmapped");
		wb(1'b1, acdr_pkg::ADDR_BAUD, 32'h3);
		$display("test regs done");
	endtask

	task automatic t_normal();
		wb(1'b1, acdr_pkg::ADDR_MASK, 32'h1);
		frame(7'h31, 9'h0a5, 8, -1, 1'b1, 64, 128, 32'h1, 32'h0a5);
		wb(1'b1, acdr_pkg::ADDR_STATUS, 32'hf);
		wb(1'b1, acdr_pkg::ADDR_MASK, 32'h0);
		$display("test normal done");
	endtask

	task automatic t_irq();
		wb(1'b1, acdr_pkg::ADDR_MASK, 32'h1);
		i_tx.send(9'h012, 8, -1, 1'b1, 64, 64);
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		chk({31'h0, irq}, 32'h1, "irq set");
		@(posedge mclk);
		wb(1'b1, acdr_pkg::ADDR_STATUS, 32'h1);
		@(negedge mclk);
		chk({31'h0, irq}, 32'h0, "irq clear");
		@(posedge mclk);
		wb(1'b1, acdr_pkg::ADDR_MASK, 32'h0);
		$display("test irq done");
	endtask

	task automatic t_errors();
		frame(7'h31, 9'h05a, 8, -1, 1'b0, 64, 64, 32'h3, 32'h25a);
		frame(7'h05, 9'h015, 5, 1, 1'b1, 64, 64, 32'h1, 32'h015);
		frame(7'h4f, 9'h1ff, 9, 1, 1'b1, 32, 32, 32'h5, 32'h5ff);
		frame(7'h61, 9'h155, 9, -1, 1'b1, 64, 64, 32'h1, 32'h155);
		$display("test errors done");
	endtask

	task automatic t_noise();
		i_tx.hold(1'b0, 16);
		i_tx.hold(1'b1, 200);
		wb(1'b0, acdr_pkg::ADDR_STATUS, 32'h0);
		chk(q, 32'h8, "noise");
		wb(1'b1, acdr_pkg::ADDR_STATUS, 32'hf);
		wb(1'b1, acdr_pkg::ADDR_CTRL, 32'h30);
		i_tx.hold(1'b0, 64);
		i_tx.hold(1'b1, 64);
		wb(1'b0, acdr_pkg::ADDR_STATUS, 32'h0);
		chk(q, 32'h0, "receiver disabled");
		$display("test noise done");
	endtask

	task automatic t_back();
		wb(1'b1, acdr_pkg::ADDR_CTRL, 32'h31);
		i_tx.send(9'h0c3, 8, -1, 1'b1, 64, 44);
		frame(7'h31, 9'h03c, 8, -1, 1'b1, 64, 64, 32'h1, 32'h03c);
		$display("test back-to-back done");
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_regs();
		t_normal();
		t_irq();
		t_errors();
		t_noise();
		t_back();
		end_sim();
	end
endmodule
`default_nettype wire
